// ==== design/rmf_top.sv ====
// Design: rail monitor filtering and fault-response engine
// Function
// [R1] Measure one rail current per 200 us slot, ten rails in turn.
// [R2] Report current as sliding average of last four samples.
// [R3] Undercurrent checks with voltage monitor start after power-good-on.
// [R4] Without voltage monitor, current monitoring starts once rail is enabled.
// [R5] Measure one rail temperature per 100 ms slot, ten rails in turn.
// [R6] Report temperature as sliding average of last sixteen samples.
// [R7] Temperature monitoring runs from reset release without condition.
// [R8] Host-written temperature replaces measurement for warnings and peak log.
// [R9] With monitor pin, use measured temperature until host first writes.
// [R10] Any voltage window violation sets status and pulls alert low; the code sets UV status and alert only in ST_RUN.
// [R11] Per-rail glitch filter, 0 to 102 ms in 400 us steps.
// [R12] Flag max turn-on fault if power-good-on not reached in time.
// [R13] Undervoltage flags only after power-good-on was reached.
// [R14] Overvoltage flags at any time.
// [R15] Flag max turn-off warning if rail not below off level in time.
// [R16] Warnings set alert, status and a warning output; nothing logged.
// [R17] Continue response only flags the fault.
// [R18] Immediate response disables rail at once, then restarts per config.
// [R19] Delayed response exhausts retries then requests sequenced shutdown.
// [R20] No restart or up to 14 restarts, gap 0 to 1275 ms in 5 ms.
// [R21] Continuous restart until fault clears, commanded off or reset.
// [R22] Resequence shuts rails down then turns them back on.
// [R23] Wait 0 to 1275 ms in 5 ms steps before resequencing on.
// [R24] Alert stays asserted until host clears pending status.
`timescale 1ns/1ns
`default_nettype none
module rmf_top #(
  parameter int CUR_SLOT_CYC = rmf_pkg::CUR_SLOT_CYC,
  parameter int TMP_SLOT_CYC = rmf_pkg::TMP_SLOT_CYC,
  parameter int GLITCH_STEP_CYC = rmf_pkg::GLITCH_STEP_CYC,
  parameter int MS_CYC = rmf_pkg::MS_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic cur_req_o,
  output logic [3:0] cur_rail_o,
  input wire logic cur_valid_i,
  input wire logic [11:0] cur_data_i,
  output logic tmp_req_o,
  output logic [3:0] tmp_rail_o,
  input wire logic tmp_valid_i,
  input wire logic [11:0] tmp_data_i,
  input wire rmf_pkg::rmf_vcmp_s [rmf_pkg::NRAIL-1:0] vcmp_i,
  output logic [rmf_pkg::NRAIL-1:0] rail_en_o,
  output logic [rmf_pkg::NRAIL-1:0] shut_req_o,
  output logic [rmf_pkg::NRAIL-1:0] warn_gpo_o,
  output logic fault_alert_out_n_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    rmf_pkg::rmf_rail_s [rmf_pkg::NRAIL-1:0] rail;
    logic [23:0] ms_cnt;
    logic [23:0] gl_cnt;
    logic [23:0] cur_cnt;
    logic [23:0] tmp_cnt;
    logic [3:0] cur_rail;
    logic [3:0] tmp_rail;
    logic cur_req;
    logic tmp_req;
    logic [31:0] rdata;
    logic [rmf_pkg::NRAIL-1:0] en;
    logic [rmf_pkg::NRAIL-1:0] shut;
    logic [rmf_pkg::NRAIL-1:0] wgpo;
    logic alert_n;
  } rmf_state_s;

  rmf_state_s q, d;
  rmf_pkg::rmf_rail_s rs;
  rmf_pkg::rmf_vcmp_s v;
  logic ms_tick, gl_tick, cur_tick, tmp_tick;
  logic viol, filt, ton_hit, fault, mon_on, t_ok, any_stat;
  logic [11:0] cavg, tavg, tval;
  logic [10:0] dly_ms;

  function automatic logic [15:0] sum16(input logic [15:0][11:0] h);
    logic [15:0] s;
    s = '0;
    for (int i = 0; i < 16; i++) begin
      s = s + 16'(h[i]);
    end
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    rs = '0;
    v = '0;
    viol = 1'b0;
    filt = 1'b0;
    ton_hit = 1'b0;
    fault = 1'b0;
    mon_on = 1'b0;
    t_ok = 1'b0;
    cavg = '0;
    tavg = '0;
    tval = '0;
    dly_ms = '0;
    any_stat = 1'b0;
    d.rdata = '0;
    d.cur_req = 1'b0;
    d.tmp_req = 1'b0;
    // Dividers give one-cycle enables for all slower rates
    ms_tick = q.ms_cnt == 24'(MS_CYC - 1);
    gl_tick = q.gl_cnt == 24'(GLITCH_STEP_CYC - 1);
    cur_tick = q.cur_cnt == 24'(CUR_SLOT_CYC - 1);
    tmp_tick = q.tmp_cnt == 24'(TMP_SLOT_CYC - 1);
    d.ms_cnt = ms_tick ? '0 : q.ms_cnt + 24'h1;
    d.gl_cnt = gl_tick ? '0 : q.gl_cnt + 24'h1;
    d.cur_cnt = cur_tick ? '0 : q.cur_cnt + 24'h1;
    d.tmp_cnt = tmp_tick ? '0 : q.tmp_cnt + 24'h1;
    // Slot schedule is fixed to ten rails whether or not each monitors current
    if (cur_tick) begin
      d.cur_req = 1'b1; // R1
      d.cur_rail = (q.cur_rail == 4'(rmf_pkg::NRAIL - 1)) ? 4'h0 : q.cur_rail + 4'h1; // R1
    end
    // Temperature slots free-run from reset release
    if (tmp_tick) begin
      d.tmp_req = 1'b1; // R5 R7
      d.tmp_rail = (q.tmp_rail == 4'(rmf_pkg::NRAIL - 1)) ? 4'h0 : q.tmp_rail + 4'h1; // R5
    end
    for (int r = 0; r < rmf_pkg::NRAIL; r++) begin
      rs = q.rail[r];
      v = vcmp_i[r];
      // ------------------------------------------------------------
      // Register writes
      // ------------------------------------------------------------
      if (wr_i && addr_i[7:4] == 4'(r)) begin
        unique case (addr_i[3:0])
          rmf_pkg::REG_CFG0: rs.cfg0 = rmf_pkg::rmf_cfg0_s'(wdata_i);
          rmf_pkg::REG_CFG1: rs.cfg1 = rmf_pkg::rmf_cfg1_s'(wdata_i);
          rmf_pkg::REG_CMD: rs.cmd = rmf_pkg::rmf_cmd_s'(wdata_i[1:0]);
          rmf_pkg::REG_STAT: rs.stat = rs.stat & ~rmf_pkg::rmf_stat_s'(wdata_i[7:0]); // R24
          rmf_pkg::REG_TEMP: begin
            rs.host = wdata_i[11:0]; // R8
            rs.hv = 1'b1; // R8
          end
          default: ;
        endcase
      end
      // ------------------------------------------------------------
      // Current and temperature filters
      // ------------------------------------------------------------
      if (cur_valid_i && q.cur_rail == 4'(r)) begin
        rs.csum = rs.csum + 14'(cur_data_i) - 14'(rs.chist[3]); // R2
        rs.chist = {rs.chist[2:0], cur_data_i}; // R2
      end
      if (tmp_valid_i && q.tmp_rail == 4'(r)) begin
        rs.tsum = rs.tsum + 16'(tmp_data_i) - 16'(rs.thist[15]); // R6
        rs.thist = {rs.thist[14:0], tmp_data_i}; // R6
      end
      cavg = rs.csum[13:2];
      tavg = rs.tsum[15:4];
      // Host value wins once written; before that only a pin-fed rail has a reading
      tval = rs.hv ? rs.host : tavg; // R8 R9
      t_ok = rs.hv | rs.cmd.tpin; // R8 R9
      mon_on = rs.cfg0.has_vmon ? (q.rail[r].st == rmf_pkg::ST_RUN) // R3
             : (q.rail[r].st == rmf_pkg::ST_TON || q.rail[r].st == rmf_pkg::ST_RUN); // R4
      // ------------------------------------------------------------
      // Fault detection; status sets after the clear so a set wins
      // ------------------------------------------------------------
      if (t_ok && tval > rs.peak) begin
        rs.peak = tval; // R8
      end
      if (t_ok && tval > rs.cfg1.ot_lim) begin
        rs.stat.ot_warn = 1'b1; // R8
      end
      if (mon_on && cavg < rs.cfg1.uc_lim) begin
        rs.stat.uc_warn = 1'b1; // R3 R4
      end
      if (v.ov_w) begin
        rs.stat.ov_warn = 1'b1; // R10 R14
      end
      if (v.ov_f) begin
        rs.stat.ov_fault = 1'b1; // R10 R14
      end
      if (q.rail[r].st == rmf_pkg::ST_RUN && v.uv_w) begin
        rs.stat.uv_warn = 1'b1; // R10 R13
      end
      if (q.rail[r].st == rmf_pkg::ST_RUN && v.uv_f) begin
        rs.stat.uv_fault = 1'b1; // R10 R13
      end
      if (ms_tick && rs.tmr != rmf_pkg::TMR_MAX) begin
        rs.tmr = rs.tmr + 11'h1;
      end
      // Glitch filter only delays the action, never the status bit
      viol = (q.rail[r].st == rmf_pkg::ST_RUN && (v.uv_f || v.ov_f)) ||
             (q.rail[r].st == rmf_pkg::ST_TON && v.ov_f);
      if (!viol) begin
        rs.gl = '0;
      end else if (gl_tick && rs.gl != rmf_pkg::GL_MAX) begin
        rs.gl = rs.gl + 8'h1; // R11
      end
      filt = viol && (!rs.cfg0.gl_en || rs.gl >= rs.cfg0.gl_steps); // R11
      ton_hit = q.rail[r].st == rmf_pkg::ST_TON && rs.cfg0.ton_max != 8'h0 && !v.pg &&
                rs.tmr >= 11'(rs.cfg0.ton_max); // R12
      if (ton_hit) begin
        rs.stat.ton_max = 1'b1; // R12
      end
      fault = filt || ton_hit;
      dly_ms = 11'(rs.cfg0.rst_dly) * 11'(rmf_pkg::RESTART_STEP_MS); // R20 R23
      // ------------------------------------------------------------
      // Fault response
      // ------------------------------------------------------------
      unique case (q.rail[r].st)
        rmf_pkg::ST_IDLE: begin
          if (!v.off && rs.cfg1.toff_max != 8'h0 && rs.tmr >= 11'(rs.cfg1.toff_max)) begin
            rs.stat.toff_warn = 1'b1; // R15
          end
          if (rs.cmd.on) begin
            rs.st = rmf_pkg::ST_TON;
            rs.tmr = '0;
            rs.rt = rs.cfg0.restarts;
          end
        end
        rmf_pkg::ST_TON, rmf_pkg::ST_RUN: begin
          if (!rs.cmd.on) begin
            rs.st = rmf_pkg::ST_IDLE; // R21
            rs.tmr = '0;
          end else if (fault && rs.cfg0.resp != rmf_pkg::RESP_CONT) begin // R17
            rs.tmr = '0;
            if (rs.rt != 4'h0) begin
              rs.st = rmf_pkg::ST_RDLY; // R18 R19 R20
              if (rs.rt != rmf_pkg::RESTART_CONT) begin
                rs.rt = rs.rt - 4'h1; // R20 R21
              end
            end else if (rs.cfg0.resp == rmf_pkg::RESP_IMM) begin
              rs.st = rmf_pkg::ST_DEAD; // R18
            end else begin
              rs.st = rmf_pkg::ST_SOFF; // R19 R22
            end
          end else if (q.rail[r].st == rmf_pkg::ST_TON && v.pg) begin
            rs.st = rmf_pkg::ST_RUN;
          end
        end
        rmf_pkg::ST_RDLY: begin
          if (!rs.cmd.on) begin
            rs.st = rmf_pkg::ST_IDLE;
          end else if (rs.tmr >= dly_ms) begin
            rs.st = rmf_pkg::ST_TON; // R20
            rs.tmr = '0;
          end
        end
        rmf_pkg::ST_SOFF: begin
          if (!v.off && rs.cfg1.toff_max != 8'h0 && rs.tmr >= 11'(rs.cfg1.toff_max)) begin
            rs.stat.toff_warn = 1'b1; // R15
          end
          if (!rs.cmd.on) begin
            rs.st = rmf_pkg::ST_IDLE;
          end else if (v.off) begin
            rs.st = (rs.cfg0.resp == rmf_pkg::RESP_RSQ) ? rmf_pkg::ST_RWAIT : rmf_pkg::ST_DEAD; // R22
            rs.tmr = '0;
          end
        end
        rmf_pkg::ST_RWAIT: begin
          if (!rs.cmd.on) begin
            rs.st = rmf_pkg::ST_IDLE;
          end else if (rs.tmr >= dly_ms) begin
            rs.st = rmf_pkg::ST_TON; // R22 R23
            rs.tmr = '0;
            rs.rt = rs.cfg0.restarts;
          end
        end
        rmf_pkg::ST_DEAD: begin
          if (!rs.cmd.on) begin
            rs.st = rmf_pkg::ST_IDLE;
            rs.tmr = '0;
          end
        end
        default: rs.st = rmf_pkg::ST_IDLE;
      endcase
      d.rail[r] = rs;
      d.en[r] = rs.st == rmf_pkg::ST_TON || rs.st == rmf_pkg::ST_RUN; // R18
      d.shut[r] = rs.st == rmf_pkg::ST_SOFF; // R19 R22
      d.wgpo[r] = rs.stat.ov_warn | rs.stat.uv_warn | rs.stat.toff_warn |
                  rs.stat.uc_warn | rs.stat.ot_warn; // R16
      any_stat = any_stat | (|rs.stat);
      // ------------------------------------------------------------
      // Register reads, answered in the next cycle
      // ------------------------------------------------------------
      if (rd_i && addr_i[7:4] == 4'(r)) begin
        unique case (addr_i[3:0])
          rmf_pkg::REG_CFG0: d.rdata = 32'(q.rail[r].cfg0);
          rmf_pkg::REG_CFG1: d.rdata = 32'(q.rail[r].cfg1);
          rmf_pkg::REG_CMD: d.rdata = {24'h0, 1'b0, q.rail[r].st, 2'h0, q.rail[r].cmd};
          rmf_pkg::REG_STAT: d.rdata = {24'h0, q.rail[r].stat};
          rmf_pkg::REG_CUR: d.rdata = {20'h0, q.rail[r].csum[13:2]}; // R2
          rmf_pkg::REG_TEMP: d.rdata = {4'h0, q.rail[r].peak, 4'h0,
                                       q.rail[r].hv ? q.rail[r].host : q.rail[r].tsum[15:4]}; // R6 R8
          default: d.rdata = '0;
        endcase
      end
    end
    // Alert follows pending status, so it only releases after host clears
    d.alert_n = ~any_stat; // R10 R24
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
      q.alert_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign cur_req_o = q.cur_req;
  assign cur_rail_o = q.cur_rail;
  assign tmp_req_o = q.tmp_req;
  assign tmp_rail_o = q.tmp_rail;
  assign rail_en_o = q.en;
  assign shut_req_o = q.shut;
  assign warn_gpo_o = q.wgpo;
  assign fault_alert_out_n_o = q.alert_n;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  property p_cur_gap;
    cur_req_o |=> !cur_req_o [*8];
  endproperty
  a_cur_gap: assert property (p_cur_gap) else $error("current slots too close"); // R1
  property p_cur_sum;
    q.rail[0].csum == 14'(q.rail[0].chist[0]) + 14'(q.rail[0].chist[1]) +
                      14'(q.rail[0].chist[2]) + 14'(q.rail[0].chist[3]);
  endproperty
  a_cur_sum: assert property (p_cur_sum) else $error("current sum off"); // R2
  property p_tmp_sum;
    q.rail[0].tsum == sum16(q.rail[0].thist);
  endproperty
  a_tmp_sum: assert property (p_tmp_sum) else $error("temperature sum off"); // R6
  property p_ov_alert;
    vcmp_i[4].ov_w |=> !fault_alert_out_n_o && q.rail[4].stat.ov_warn;
  endproperty
  a_ov_alert: assert property (p_ov_alert) else $error("ov warn did not alert"); // R10
  property p_ov_fault;
    vcmp_i[4].ov_f |=> q.rail[4].stat.ov_fault && !fault_alert_out_n_o;
  endproperty
  a_ov_fault: assert property (p_ov_fault) else $error("ov fault not flagged"); // R14
  property p_uv_gate;
    q.rail[5].st != rmf_pkg::ST_RUN && !q.rail[5].stat.uv_fault && !wr_i |=> !q.rail[5].stat.uv_fault;
  endproperty
  a_uv_gate: assert property (p_uv_gate) else $error("uv flagged before power good"); // R13
  property p_ton_max;
    q.rail[9].st == rmf_pkg::ST_TON && q.rail[9].cfg0.ton_max != 8'h0 && !vcmp_i[9].pg &&
    q.rail[9].tmr >= 11'(q.rail[9].cfg0.ton_max) |=> q.rail[9].stat.ton_max;
  endproperty
  a_ton_max: assert property (p_ton_max) else $error("max turn-on not flagged"); // R12
  property p_cont;
    q.rail[4].st == rmf_pkg::ST_RUN && q.rail[4].cfg0.resp == rmf_pkg::RESP_CONT &&
    q.rail[4].cmd.on && !wr_i |=> rail_en_o[4] ##1 rail_en_o[4];
  endproperty
  a_cont: assert property (p_cont) else $error("continue response acted"); // R17
  property p_imm;
    q.rail[5].st == rmf_pkg::ST_RUN && q.rail[5].cfg0.resp == rmf_pkg::RESP_IMM &&
    !q.rail[5].cfg0.gl_en && vcmp_i[5].uv_f |=> !rail_en_o[5];
  endproperty
  a_imm: assert property (p_imm) else $error("immediate shutdown missing"); // R18
  property p_alert_hold;
    !fault_alert_out_n_o && !wr_i |=> !fault_alert_out_n_o;
  endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert released without clear"); // R24

  c_cur: cover property (cur_req_o ##1 cur_valid_i);
  c_run: cover property (q.rail[4].st == rmf_pkg::ST_TON ##1 q.rail[4].st == rmf_pkg::ST_RUN);
  c_shut: cover property (shut_req_o[8]);
  c_alert: cover property ($fell(fault_alert_out_n_o));
endmodule // rmf_top
`default_nettype wire

// ==== include/rmf_pkg.sv ====
// Package: constants and types of the rail monitor and fault-response block
package rmf_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int NRAIL = 10;
  localparam int CUR_SLOT_US = 200;
  localparam int CUR_SLOT_CYC = CUR_SLOT_US * CLK_MHZ;
  localparam int TMP_SLOT_MS = 100;
  localparam int TMP_SLOT_CYC = TMP_SLOT_MS * 1000 * CLK_MHZ;
  localparam int GLITCH_STEP_US = 400;
  localparam int GLITCH_STEP_CYC = GLITCH_STEP_US * CLK_MHZ;
  localparam int MS_CYC = 1000 * CLK_MHZ;
  localparam logic [2:0] RESTART_STEP_MS = 3'h5;
  localparam logic [3:0] RESTART_CONT = 4'hF;
  localparam logic [10:0] TMR_MAX = 11'h7FF;
  localparam logic [7:0] GL_MAX = 8'hFF;
  // ----------------------------------------------------------------
  // Register indices (addr[7:4] rail, addr[3:0] index)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CFG0 = 4'h0;
  localparam logic [3:0] REG_CFG1 = 4'h1;
  localparam logic [3:0] REG_CMD = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_CUR = 4'h4;
  localparam logic [3:0] REG_TEMP = 4'h5;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RESP_CONT = 2'h0, RESP_IMM = 2'h1, RESP_DLY = 2'h2, RESP_RSQ = 2'h3
  } rmf_resp_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_TON = 3'h1, ST_RUN = 3'h2, ST_RDLY = 3'h3,
    ST_SOFF = 3'h4, ST_RWAIT = 3'h5, ST_DEAD = 3'h6
  } rmf_st_e;
  typedef struct packed {
    logic [7:0] ton_max;
    logic [7:0] rst_dly;
    logic [7:0] gl_steps;
    logic has_vmon;
    logic gl_en;
    logic [3:0] restarts;
    rmf_resp_e resp;
  } rmf_cfg0_s;
  typedef struct packed {
    logic [7:0] toff_max;
    logic [11:0] ot_lim;
    logic [11:0] uc_lim;
  } rmf_cfg1_s;
  typedef struct packed {
    logic tpin;
    logic on;
  } rmf_cmd_s;
  typedef struct packed {
    logic ot_warn;
    logic uc_warn;
    logic toff_warn;
    logic ton_max;
    logic uv_fault;
    logic uv_warn;
    logic ov_fault;
    logic ov_warn;
  } rmf_stat_s;
  typedef struct packed {
    logic off;
    logic pg;
    logic uv_f;
    logic uv_w;
    logic ov_w;
    logic ov_f;
  } rmf_vcmp_s;
  typedef struct packed {
    rmf_st_e st;
    logic [10:0] tmr;
    logic [7:0] gl;
    logic [3:0] rt;
    rmf_stat_s stat;
    logic [3:0][11:0] chist;
    logic [13:0] csum;
    logic [15:0][11:0] thist;
    logic [15:0] tsum;
    logic [11:0] host;
    logic hv;
    logic [11:0] peak;
    rmf_cfg0_s cfg0;
    rmf_cfg1_s cfg1;
    rmf_cmd_s cmd;
  } rmf_rail_s;
  localparam rmf_rail_s RAIL_RST = '0;
endpackage

// ==== tb/rmf_rail_model.sv ====
// Partner model: converter answering slots and the monitored rails
`timescale 1ns/1ns
`default_nettype none
module rmf_rail_model (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic cur_req_i,
  input wire logic tmp_req_i,
  input wire logic [11:0] cur_val_i,
  input wire logic [11:0] tmp_val_i,
  input wire logic [rmf_pkg::NRAIL-1:0] rail_en_i,
  input wire logic [rmf_pkg::NRAIL-1:0] blk_i,
  input wire logic [rmf_pkg::NRAIL-1:0][3:0] flt_i,
  output logic cur_valid_o,
  output logic [11:0] cur_data_o,
  output logic tmp_valid_o,
  output logic [11:0] tmp_data_o,
  output rmf_pkg::rmf_vcmp_s [rmf_pkg::NRAIL-1:0] vcmp_o
);
  logic [2:0] cur_dly_q;
  logic [2:0] tmp_dly_q;
  logic [3:0][rmf_pkg::NRAIL-1:0] en_hist_q;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cur_dly_q <= 3'h0;
      tmp_dly_q <= 3'h0;
      en_hist_q <= '0;
    end else begin
      cur_dly_q <= {cur_dly_q[1:0], cur_req_i};
      tmp_dly_q <= {tmp_dly_q[1:0], tmp_req_i};
      en_hist_q <= {en_hist_q[2:0], rail_en_i};
    end
  end
  // Data lines show the inverse outside a sample so stale values never match
  assign cur_valid_o = cur_dly_q[2];
  assign cur_data_o = cur_dly_q[2] ? cur_val_i : ~cur_val_i;
  assign tmp_valid_o = tmp_dly_q[2];
  assign tmp_data_o = tmp_dly_q[2] ? tmp_val_i : ~tmp_val_i;
  // Rail rises to power good four cycles after enable; blk holds it stuck
  always_comb begin
    for (int i = 0; i < rmf_pkg::NRAIL; i++) begin
      vcmp_o[i].off = !rail_en_i[i] && !blk_i[i];
      vcmp_o[i].pg = rail_en_i[i] && en_hist_q[3][i] && !blk_i[i];
      {vcmp_o[i].uv_f, vcmp_o[i].uv_w, vcmp_o[i].ov_w, vcmp_o[i].ov_f} = flt_i[i];
    end
  end
endmodule // rmf_rail_model
`default_nettype wire

// ==== tb/tb_rail_monitor_fault_response.sv ====
// Testbench: rail monitor filtering and fault responses
`timescale 1ns/1ns
`default_nettype none
module tb_rail_monitor_fault_response;
  logic clk_sys_i, reset_i, wr_i, rd_i, cur_req_o, cur_valid_i, tmp_req_o, tmp_valid_i, fault_alert_out_n_o;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [3:0] cur_rail_o, tmp_rail_o;
  logic [11:0] cur_data_i, tmp_data_i, cur_val, tmp_val;
  rmf_pkg::rmf_vcmp_s [rmf_pkg::NRAIL-1:0] vcmp_i;
  logic [rmf_pkg::NRAIL-1:0] rail_en_o, shut_req_o, warn_gpo_o, blk;
  logic [rmf_pkg::NRAIL-1:0][3:0] flt;
  int miscompares = 0;
  int num_checks = 0;
  localparam int CSLOT = 20;
  rmf_top #(.CUR_SLOT_CYC(CSLOT), .TMP_SLOT_CYC(40), .GLITCH_STEP_CYC(8), .MS_CYC(16)) i_rmf_top (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .cur_req_o(cur_req_o), .cur_rail_o(cur_rail_o), .cur_valid_i(cur_valid_i),
    .cur_data_i(cur_data_i), .tmp_req_o(tmp_req_o), .tmp_rail_o(tmp_rail_o), .tmp_valid_i(tmp_valid_i),
    .tmp_data_i(tmp_data_i), .vcmp_i(vcmp_i), .rail_en_o(rail_en_o), .shut_req_o(shut_req_o),
    .warn_gpo_o(warn_gpo_o), .fault_alert_out_n_o(fault_alert_out_n_o));
  rmf_rail_model i_rmf_rail_model (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .cur_req_i(cur_req_o), .tmp_req_i(tmp_req_o),
    .cur_val_i(cur_val), .tmp_val_i(tmp_val), .rail_en_i(rail_en_o), .blk_i(blk), .flt_i(flt),
    .cur_valid_o(cur_valid_i), .cur_data_o(cur_data_i), .tmp_valid_o(tmp_valid_i),
    .tmp_data_o(tmp_data_i), .vcmp_o(vcmp_i));
  always #4 clk_sys_i = ~clk_sys_i;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  function automatic logic [31:0] cfg0(input logic [7:0] ton, input logic [7:0] rst, input logic [3:0] rs,
                                      input logic [1:0] rp);
    return {ton, rst, 8'h00, 1'b1, 1'b0, rs, rp};
  endfunction
  task automatic wait_req(input logic tsel, input logic [3:0] r);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (!((tsel ? tmp_req_o : cur_req_o) === 1'b1 && (tsel ? tmp_rail_o : cur_rail_o) === r) && n < 1000);
    chk(n < 1000, 1'b1);
  endtask
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    @(negedge clk_sys_i);
    chk(fault_alert_out_n_o, 1'b1);
    rd(8'hA0, d);
    chk(d, 32'h0);
    rd({4'h0, rmf_pkg::REG_STAT}, d);
    chk(d, 32'h0);
  endtask
  task automatic t_cur();
    int n;
    logic [31:0] d;
    @(posedge clk_sys_i) cur_val <= 12'h100;
    repeat (5) wait_req(1'b0, 4'h1);
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (cur_req_o !== 1'b1 && n < 100);
    chk(n, CSLOT);
    chk(cur_rail_o, 4'h2);
    rd({4'h1, rmf_pkg::REG_CUR}, d);
    chk(d[11:0], 12'h100);
    @(posedge clk_sys_i) cur_val <= 12'h200;
    repeat (2) wait_req(1'b0, 4'h1);
    repeat (5) @(negedge clk_sys_i);
    rd({4'h1, rmf_pkg::REG_CUR}, d);
    chk(d[11:0], 12'h180);
  endtask
  task automatic t_tmp();
    logic [31:0] d;
    wr({4'h3, rmf_pkg::REG_CMD}, 32'h2);
    wr({4'h3, rmf_pkg::REG_CFG1}, 32'h000F_F000);
    @(posedge clk_sys_i) tmp_val <= 12'h0A0;
    repeat (17) wait_req(1'b1, 4'h3);
    repeat (5) @(negedge clk_sys_i);
    rd({4'h3, rmf_pkg::REG_TEMP}, d);
    chk(d[11:0], 12'h0A0);
    @(posedge clk_sys_i) tmp_val <= 12'h1A0;
    repeat (8) wait_req(1'b1, 4'h3);
    repeat (5) @(negedge clk_sys_i);
    rd({4'h3, rmf_pkg::REG_TEMP}, d);
    chk(d[11:0], 12'h120);
    wr({4'h3, rmf_pkg::REG_TEMP}, 32'h033);
    wait_req(1'b1, 4'h3);
    repeat (5) @(negedge clk_sys_i);
    rd({4'h3, rmf_pkg::REG_TEMP}, d);
    chk(d[27:0], 28'h1200033);
    rd({4'h3, rmf_pkg::REG_STAT}, d);
    chk(d[7:0], 8'h80);
    wr({4'h3, rmf_pkg::REG_STAT}, 32'hFF);
  endtask
  task automatic t_alert();
    logic [31:0] d;
    wr({4'h4, rmf_pkg::REG_CFG0}, cfg0(8'h00, 8'h00, 4'h0, rmf_pkg::RESP_CONT));
    wr({4'h4, rmf_pkg::REG_CMD}, 32'h1);
    repeat (10) @(posedge clk_sys_i);
    flt[4] <= 4'b0011;
    repeat (3) @(negedge clk_sys_i);
    chk(fault_alert_out_n_o, 1'b0);
    chk(warn_gpo_o[4], 1'b1);
    rd({4'h4, rmf_pkg::REG_STAT}, d);
    chk(d[7:0], 8'h03);
    @(posedge clk_sys_i) flt[4] <= 4'b0000;
    repeat (5) @(negedge clk_sys_i);
    chk(fault_alert_out_n_o, 1'b0);
    chk(rail_en_o[4], 1'b1);
    wr({4'h4, rmf_pkg::REG_STAT}, 32'hFF);
    repeat (3) @(negedge clk_sys_i);
    chk(fault_alert_out_n_o, 1'b1);
  endtask
  task automatic t_imm();
    int rises;
    logic prev;
    logic [31:0] d;
    @(posedge clk_sys_i) flt[5] <= 4'b1000;
    repeat (10) @(negedge clk_sys_i);
    rd({4'h5, rmf_pkg::REG_STAT}, d);
    chk(d, 32'h0);
    wr({4'h5, rmf_pkg::REG_CFG0}, cfg0(8'h00, 8'h01, 4'h2, rmf_pkg::RESP_IMM));
    wr({4'h5, rmf_pkg::REG_CMD}, 32'h1);
    rises = 0;
    prev = 1'b0;
    repeat (1000) begin
      @(negedge clk_sys_i);
      if (rail_en_o[5] === 1'b1 && !prev) rises++;
      prev = rail_en_o[5];
    end
    chk(rises, 3);
    rd({4'h5, rmf_pkg::REG_CMD}, d);
    chk(d[6:4], rmf_pkg::ST_DEAD);
    @(posedge clk_sys_i) flt[5] <= 4'b0000;
    wr({4'h5, rmf_pkg::REG_CMD}, 32'h0);
  endtask
  task automatic t_seq(input logic [3:0] r);
    int n;
    wr({r, rmf_pkg::REG_CFG0}, cfg0(8'h00, 8'h01, 4'h0, (r == 4'h7) ? rmf_pkg::RESP_DLY : rmf_pkg::RESP_RSQ) |
       ((r == 4'h7) ? 32'h240 : 32'h0));
    wr({r, rmf_pkg::REG_CMD}, 32'h1);
    repeat (10) @(posedge clk_sys_i);
    flt[r] <= 4'b0001;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (shut_req_o[r] !== 1'b1 && n < 50);
    chk(n < 50 && (r != 4'h7 || n > 8), 1'b1);
    @(posedge clk_sys_i) flt[r] <= 4'b0000;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (rail_en_o[r] !== 1'b1 && n < 300);
    if (r == 4'h8) chk(n >= 56 && n <= 90, 1'b1);
    else chk(rail_en_o[r], 1'b0);
    wr({r, rmf_pkg::REG_CMD}, 32'h0);
  endtask
  task automatic t_ton();
    logic [31:0] d;
    wr({4'h9, rmf_pkg::REG_CFG1}, 32'h0200_0000);
    wr({4'h9, rmf_pkg::REG_CFG0}, cfg0(8'h02, 8'h00, 4'h0, rmf_pkg::RESP_CONT));
    @(posedge clk_sys_i) blk[9] <= 1'b1;
    wr({4'h9, rmf_pkg::REG_CMD}, 32'h1);
    repeat (60) @(negedge clk_sys_i);
    rd({4'h9, rmf_pkg::REG_STAT}, d);
    chk(d[4], 1'b1);
    wr({4'h9, rmf_pkg::REG_CMD}, 32'h0);
    wr({4'h9, rmf_pkg::REG_STAT}, 32'hFF);
    repeat (60) @(negedge clk_sys_i);
    rd({4'h9, rmf_pkg::REG_STAT}, d);
    chk(d[5:4], 2'b10);
  endtask
  initial begin
    clk_sys_i = 1'b0;
    reset_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    cur_val = 12'h000;
    tmp_val = 12'h000;
    blk = '0;
    flt = '0;
    repeat (20) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    t_reset();
    t_cur();
    t_tmp();
    t_alert();
    t_imm();
    t_seq(4'h7);
    t_seq(4'h8);
    t_ton();
    print_verdict();
  end
  // Whole run takes about 15000 cycles; four times that means a hang
  initial begin
    #(60000 * 8);
    miscompares++;
    print_verdict();
  end
endmodule // tb_rail_monitor_fault_response
`default_nettype wire
